// ---- rtl/asep_pkg.sv ----
// Package: parameter numbers, field layouts and constants of the axis status block
package asep_pkg;

   // ---------------------------------------------------------------
   // Parameter numbers (reached by parameter command, not bus address)
   // ---------------------------------------------------------------
   localparam logic [7:0] ASEP_PAR_STANDSTILL = 8'hCC;
   localparam logic [7:0] ASEP_PAR_LOAD       = 8'hCE;
   localparam logic [7:0] ASEP_PAR_STICKY     = 8'hCF;
   localparam logic [7:0] ASEP_PAR_DIAG       = 8'hD0;
   localparam logic [7:0] ASEP_PAR_ENC_COUNT  = 8'hD1;
   localparam logic [7:0] ASEP_PAR_ENC_ARM    = 8'hD2;

   // ---------------------------------------------------------------
   // Field positions and encodings
   // ---------------------------------------------------------------
   localparam int ASEP_STICKY_STALL_BIT = 0;
   localparam int ASEP_STICKY_DEV_BIT   = 1;
   localparam int ASEP_DIAG_STALL_BIT   = 0;
   localparam int ASEP_DIAG_OT_BIT      = 1;
   localparam int ASEP_DIAG_OTPW_BIT    = 2;
   localparam int ASEP_DIAG_SGA_BIT     = 3;
   localparam int ASEP_DIAG_SGB_BIT     = 4;
   localparam int ASEP_DIAG_OLA_BIT     = 5;
   localparam int ASEP_DIAG_OLB_BIT     = 6;
   localparam int ASEP_DIAG_STST_BIT    = 7;
   localparam int ASEP_LOAD_MAX         = 1023;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [1:0]  ASEP_STANDSTILL_RST = 2'h0;
   localparam logic [1:0]  ASEP_STICKY_RST     = 2'h0;
   localparam logic [31:0] ASEP_ENC_RST        = 32'h0000_0000;
   localparam logic        ASEP_ARM_RST        = 1'h0;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int ASEP_STST_LOG2 = 20;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ASEP_COIL_NORMAL  = 2'b00,
      ASEP_COIL_FREE    = 2'b01,
      ASEP_COIL_SHORT_L = 2'b10,
      ASEP_COIL_SHORT_H = 2'b11
   } asep_coil_t;

   typedef struct packed
   {
      logic        valid;
      logic        write;
      logic [7:0]  num;
      logic [31:0] wdata;
   } asep_cmd_t;

   typedef struct packed
   {
      logic        valid;
      logic        error;
      logic [31:0] rdata;
   } asep_rsp_t;

   typedef struct packed
   {
      logic stall;
      logic ot;
      logic otpw;
      logic s2ga;
      logic s2gb;
      logic ola;
      logic olb;
   } asep_drv_t;

endpackage

// ---- rtl/asep_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/100ps
module asep_sync
#(
   parameter int W = 1
)
(
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q      <= '0;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ---- rtl/asep_standstill.sv ----
// Standstill detector: no step pulse for 2^N clock cycles
`timescale 1ns/100ps
module asep_standstill
#(
   parameter int N = asep_pkg::ASEP_STST_LOG2
)
(
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic step_seen,
   output logic      stst
);
   import asep_pkg::*;

   logic [N:0] cnt_r;

   // Checked while the design is built, so a bad width never reaches a run
   if (N < 1 || N > 30)
   begin : g_bad_n
      $error("asep_standstill: N out of range");
   end

   // Counter saturates at 2^N; any step restarts it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         cnt_r <= '0;
      else if (step_seen)
         cnt_r <= '0;
      else if (!cnt_r[N])
         cnt_r <= cnt_r + 1'b1;
   end

   assign stst = cnt_r[N];

   stst_bound_a: assert property (@(posedge mclk) disable iff (rst)
      step_seen |=> !stst) else $error("standstill set right after a step");
endmodule

// ---- rtl/asep_axis_status.sv ----
// Axis status and built-in encoder parameters with command port
`timescale 1ns/100ps
// Behaviour
// - Standstill coil option acts only with zero standby current and voltage-mode chopper.
// - Coil option: 1 freewheel, 2 short low side, 3 short high side.
// - Load value readable, range 0 to 1023.
// - Sticky word: 1 stall, 2 deviation; cleared once read.
// - Any motion command clears both sticky flags.
// - Diag bit 0 stall, bit 1 overtemperature shutdown.
// - Diag bit 2 overtemperature early warning.
// - Diag bits 3,4 short to ground coil A, B.
// - Diag bits 5,6 open load coil A, B.
// - Diag bit 7 standstill: no step for 2^20 cycles.
// - Encoder counter read/write as signed 32-bit value.
// - Armed clear-on-zero resets encoder count at zero position.
// - Arm bit self-clears after the clear fires once.
module asep_axis_status
#(
   parameter int STST_LOG2 = asep_pkg::ASEP_STST_LOG2
)
(
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire asep_pkg::asep_cmd_t    cmd,
   output asep_pkg::asep_rsp_t         rsp,
   input  wire logic                   motion_cmd,
   input  wire logic                   stall_event,
   input  wire logic                   dev_event,
   input  wire logic [9:0]             load_in,
   input  wire asep_pkg::asep_drv_t    drv_in,
   input  wire logic                   step_pulse,
   input  wire logic                   enc_inc,
   input  wire logic                   enc_dec,
   input  wire logic                   enc_zero,
   input  wire logic                   standby_zero,
   input  wire logic                   volt_mode,
   output asep_pkg::asep_coil_t        coil_mode
);
   import asep_pkg::*;

   // ---------------------------------------------------------------
   // Input synchronisation
   // ---------------------------------------------------------------
   asep_drv_t drv_s;
   logic [9:0] load_s;
   logic step_s;
   logic step_d_r;
   logic stst;

   // Load bits are synchronised one by one, so a read while it moves may mix
   // old and new bits; the load figure changes slowly, so this is accepted
   asep_sync #(.W(18)) u_sync
   (
      .mclk (mclk),
      .rst  (rst),
      .d    ({drv_in, load_in, step_pulse}),
      .q    ({drv_s, load_s, step_s})
   );

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         step_d_r <= 1'b0;
      else
         step_d_r <= step_s;
   end

   asep_standstill #(.N(STST_LOG2)) u_stst
   (
      .mclk      (mclk),
      .rst       (rst),
      .step_seen (step_s & ~step_d_r),
      .stst      (stst)
   );

   // ---------------------------------------------------------------
   // Command decode
   // ---------------------------------------------------------------
   logic wr;
   logic rd;
   assign wr = cmd.valid && cmd.write;
   assign rd = cmd.valid && !cmd.write;

   logic known;
   always_comb
   begin
      case (cmd.num)
         ASEP_PAR_STANDSTILL, ASEP_PAR_LOAD, ASEP_PAR_STICKY,
         ASEP_PAR_DIAG, ASEP_PAR_ENC_COUNT, ASEP_PAR_ENC_ARM: known = 1'b1;
         default:                                           known = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // Standstill coil option
   // ---------------------------------------------------------------
   // Value 0 keeps the normal standstill hold; it is not one of the options
   logic [1:0] coil_opt_r;

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         coil_opt_r <= ASEP_STANDSTILL_RST;
      else if (wr && cmd.num == ASEP_PAR_STANDSTILL)
         coil_opt_r <= cmd.wdata[1:0];
   end

   // Only applied while stopped, with zero standby current in voltage mode
   always_comb
   begin
      if (stst && standby_zero && volt_mode)
         coil_mode = asep_coil_t'(coil_opt_r);
      else
         coil_mode = ASEP_COIL_NORMAL;
   end

   // ---------------------------------------------------------------
   // Sticky fault flags
   // ---------------------------------------------------------------
   // A write to this word is refused and leaves both flags as they are
   logic [1:0] sticky_r;
   logic       sticky_clr;
   logic [1:0] sticky_set;

   assign sticky_clr = (rd && cmd.num == ASEP_PAR_STICKY) || motion_cmd;
   assign sticky_set = {dev_event, stall_event};

   // Set beats clear so an event arriving with the read is kept for next time
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         sticky_r <= ASEP_STICKY_RST;
      else
         sticky_r <= (sticky_clr ? 2'h0 : sticky_r) | sticky_set;
   end

   // ---------------------------------------------------------------
   // Driver diagnostic flags, live
   // ---------------------------------------------------------------
   // Bit 7 is not a fault: it comes from the standstill counter
   logic [7:0] diag;
   always_comb
   begin
      diag                      = 8'h00;
      diag[ASEP_DIAG_STALL_BIT] = drv_s.stall;
      diag[ASEP_DIAG_OT_BIT]    = drv_s.ot;
      diag[ASEP_DIAG_OTPW_BIT]  = drv_s.otpw;
      diag[ASEP_DIAG_SGA_BIT]   = drv_s.s2ga;
      diag[ASEP_DIAG_SGB_BIT]   = drv_s.s2gb;
      diag[ASEP_DIAG_OLA_BIT]   = drv_s.ola;
      diag[ASEP_DIAG_OLB_BIT]   = drv_s.olb;
      diag[ASEP_DIAG_STST_BIT]  = stst;
   end

   // ---------------------------------------------------------------
   // Built-in encoder counter and clear-on-zero arm
   // ---------------------------------------------------------------
   logic [31:0] enc_r;
   logic        arm_r;
   logic        zero_fire;
   logic        arm_wr;

   assign zero_fire = arm_r && enc_zero;
   assign arm_wr    = wr && cmd.num == ASEP_PAR_ENC_ARM;

   // Host write beats counting; the zero clear beats both
   // Both directions at once cancel, as one step each way
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         enc_r <= ASEP_ENC_RST;
      else if (zero_fire)
         enc_r <= ASEP_ENC_RST;
      else if (wr && cmd.num == ASEP_PAR_ENC_COUNT)
         enc_r <= cmd.wdata;
      else if (enc_inc && !enc_dec)
         enc_r <= enc_r + 32'h0000_0001;
      else if (enc_dec && !enc_inc)
         enc_r <= enc_r - 32'h0000_0001;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         arm_r <= ASEP_ARM_RST;
      else if (zero_fire)
         arm_r <= 1'b0;
      else if (arm_wr)
         arm_r <= cmd.wdata[0];
   end

   // ---------------------------------------------------------------
   // Read answer, one cycle after the command
   // ---------------------------------------------------------------
   logic [31:0] rd_nxt;
   always_comb
   begin
      case (cmd.num)
         ASEP_PAR_STANDSTILL: rd_nxt = {30'h0, coil_opt_r};
         ASEP_PAR_LOAD:       rd_nxt = {22'h0, load_s};
         ASEP_PAR_STICKY:     rd_nxt = {30'h0, sticky_r};
         ASEP_PAR_DIAG:       rd_nxt = {24'h0, diag};
         ASEP_PAR_ENC_COUNT:  rd_nxt = enc_r;
         ASEP_PAR_ENC_ARM:    rd_nxt = {31'h0, arm_r};
         default:             rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         rsp <= '0;
      else
      begin
         rsp.valid <= cmd.valid;
         // The error lets a host tell a mistyped number from a stored zero
         // Writes to read-only numbers and unknown numbers answer with error
         rsp.error <= cmd.valid && (!known || (cmd.write &&
                      (cmd.num == ASEP_PAR_LOAD || cmd.num == ASEP_PAR_STICKY ||
                       cmd.num == ASEP_PAR_DIAG)));
         rsp.rdata <= rd ? rd_nxt : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   coil_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !(stst && standby_zero && volt_mode) |-> coil_mode == ASEP_COIL_NORMAL)
      else $error("coil option applied outside standstill conditions");

   coil_map_a: assert property (@(posedge mclk) disable iff (rst)
      (stst && standby_zero && volt_mode) |-> coil_mode == asep_coil_t'(coil_opt_r))
      else $error("coil option not passed through");

   load_range_a: assert property (@(posedge mclk) disable iff (rst)
      (rd && cmd.num == ASEP_PAR_LOAD)
      |=> rsp.rdata <= ASEP_LOAD_MAX && rsp.rdata[9:0] == $past(load_s))
      else $error("load value out of range");

   sticky_read_a: assert property (@(posedge mclk) disable iff (rst)
      (rd && cmd.num == ASEP_PAR_STICKY && !stall_event && !dev_event)
      |=> sticky_r == 2'h0 && rsp.rdata[1:0] == $past(sticky_r))
      else $error("sticky flags not returned then cleared");

   sticky_set_a: assert property (@(posedge mclk) disable iff (rst)
      stall_event |=> sticky_r[ASEP_STICKY_STALL_BIT])
      else $error("stall event lost");

   motion_clr_a: assert property (@(posedge mclk) disable iff (rst)
      (motion_cmd && !stall_event && !dev_event) |=> sticky_r == 2'h0)
      else $error("motion command did not clear sticky flags");

   diag_live_a: assert property (@(posedge mclk) disable iff (rst)
      (rd && cmd.num == ASEP_PAR_DIAG) |=> rsp.rdata[7:0] == $past(diag))
      else $error("diag read not live");

   diag_map_a: assert property (@(posedge mclk) disable iff (rst)
      diag[ASEP_DIAG_OT_BIT] == drv_s.ot && diag[ASEP_DIAG_STST_BIT] == stst)
      else $error("diag bit mapping wrong");

   enc_write_a: assert property (@(posedge mclk) disable iff (rst)
      (wr && cmd.num == ASEP_PAR_ENC_COUNT && !zero_fire) |=> enc_r == $past(cmd.wdata))
      else $error("encoder write not stored");

   zero_clear_a: assert property (@(posedge mclk) disable iff (rst)
      zero_fire |=> enc_r == 32'h0000_0000 && !arm_r)
      else $error("zero clear did not fire once");

   arm_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (arm_r && !enc_zero && !arm_wr) |=> arm_r)
      else $error("arm dropped without a clear");

   // Fault bit placement, stores, counting, refusals and sticky flag retention
   diag_fault_a: assert property (@(posedge mclk) disable iff (rst)
      diag[6:0] == {drv_s.olb, drv_s.ola, drv_s.s2gb, drv_s.s2ga, drv_s.otpw, drv_s.ot,
                    drv_s.stall})
      else $error("driver fault bits misplaced");
   coil_store_a: assert property (@(posedge mclk) disable iff (rst)
      (wr && cmd.num == ASEP_PAR_STANDSTILL) |=> coil_opt_r == $past(cmd.wdata[1:0]))
      else $error("coil option write not stored");
   enc_up_a: assert property (@(posedge mclk) disable iff (rst)
      (enc_inc && !enc_dec && !zero_fire && !(wr && cmd.num == ASEP_PAR_ENC_COUNT))
      |=> enc_r == $past(enc_r) + 32'h0000_0001)
      else $error("encoder count did not step up");
   enc_down_a: assert property (@(posedge mclk) disable iff (rst)
      (enc_dec && !enc_inc && !zero_fire && !(wr && cmd.num == ASEP_PAR_ENC_COUNT))
      |=> enc_r == $past(enc_r) - 32'h0000_0001)
      else $error("encoder count did not step down");
   enc_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (enc_inc && enc_dec && !zero_fire && !(wr && cmd.num == ASEP_PAR_ENC_COUNT))
      |=> enc_r == $past(enc_r))
      else $error("encoder count moved with both directions");
   arm_store_a: assert property (@(posedge mclk) disable iff (rst)
      (arm_wr && !zero_fire) |=> arm_r == $past(cmd.wdata[0]))
      else $error("arm write not stored");
   ro_refuse_a: assert property (@(posedge mclk) disable iff (rst)
      (wr && cmd.num == ASEP_PAR_STICKY && !stall_event && !dev_event && !motion_cmd)
      |=> rsp.error && sticky_r == $past(sticky_r))
      else $error("write to sticky word not refused");
   sticky_keep_a: assert property (@(posedge mclk) disable iff (rst)
      !sticky_clr |=> (sticky_r & $past(sticky_r)) == $past(sticky_r))
      else $error("sticky flag lost without a clear");

   c_sticky_read: cover property (@(posedge mclk) disable iff (rst)
      sticky_r != 2'h0 ##1 (rd && cmd.num == ASEP_PAR_STICKY));
   c_zero_fire: cover property (@(posedge mclk) disable iff (rst) zero_fire);
   c_freewheel: cover property (@(posedge mclk) disable iff (rst)
      coil_mode == ASEP_COIL_FREE);
   c_set_clr: cover property (@(posedge mclk) disable iff (rst)
      stall_event && sticky_clr);
   c_short_high: cover property (@(posedge mclk) disable iff (rst)
      coil_mode == ASEP_COIL_SHORT_H);
endmodule

// ---- bench/asep_host_model.sv ----
// Host model: issues one parameter command per request and captures the reply
`timescale 1ns/100ps
module asep_host_model
(
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                go,
   input  wire logic                wr,
   input  wire logic [7:0]          num,
   input  wire logic [31:0]         wd,
   output asep_pkg::asep_cmd_t      cmd,
   input  wire asep_pkg::asep_rsp_t rsp,
   output logic                     done,
   output logic [31:0]              rdata,
   output logic                     err
);
   import asep_pkg::*;
   // Command valid lasts exactly one cycle per request
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         cmd <= '0;
      else
         cmd <= go ? {1'b1, wr, num, wd} : '0;
   // Whole word captured once; flags are gone after this read
   always_ff @(posedge mclk or posedge rst)
      if (rst)
      begin
         done  <= 1'b0;
         rdata <= 32'h0;
         err   <= 1'b0;
      end
      else
      begin
         done <= rsp.valid;
         if (rsp.valid)
         begin
            rdata <= rsp.rdata;
            err   <= rsp.error;
         end
      end
endmodule

// ---- bench/asep_axis_status_tb.sv ----
// Testbench for the axis status block: parameter command sequences with expected values
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module asep_axis_status_tb;
   import asep_pkg::*;
   logic mclk = 0, rst = 1, go = 0, wr = 0, motion_cmd = 0, stall_event = 0, dev_event = 0;
   logic step_pulse = 0, enc_inc = 0, enc_dec = 0, enc_zero = 0, standby_zero = 0;
   logic volt_mode = 0, done, err, er;
   logic [7:0]  num = 8'h00;
   logic [31:0] wd = 32'h0, rdata, rd;
   logic [9:0]  load_in = 10'h000;
   asep_drv_t   drv_in = '0;
   asep_cmd_t   cmd;
   asep_rsp_t   rsp;
   asep_coil_t  coil_mode;
   int failures = 0, comparisons = 0;

   asep_axis_status #(.STST_LOG2(4)) dut (.mclk(mclk), .rst(rst), .cmd(cmd), .rsp(rsp),
      .motion_cmd(motion_cmd), .stall_event(stall_event), .dev_event(dev_event),
      .load_in(load_in), .drv_in(drv_in), .step_pulse(step_pulse), .enc_inc(enc_inc),
      .enc_dec(enc_dec), .enc_zero(enc_zero), .standby_zero(standby_zero),
      .volt_mode(volt_mode), .coil_mode(coil_mode));
   asep_host_model host (.mclk(mclk), .rst(rst), .go(go), .wr(wr), .num(num), .wd(wd),
      .cmd(cmd), .rsp(rsp), .done(done), .rdata(rdata), .err(err));

   initial forever #5 mclk = ~mclk;

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task tick(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task acc(input logic w, input logic [7:0] n, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      go <= 1'b1;
      wr <= w;
      num <= n;
      wd <= d;
      @(posedge mclk);
      go <= 1'b0;
      while (done !== 1'b1 && k < 8)
      begin
         @(posedge mclk);
         k++;
      end
      if (k == 8)
      begin
         failures++;
         $display("MISMATCH reply expected 1 seen 0");
      end
      rd = rdata;
      er = err;
   endtask
   task tally_and_finish;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge mclk);
      failures++;
      tally_and_finish;
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      tick(2);
      rst <= 1'b0;
      tick(20);
      acc(0, ASEP_PAR_STANDSTILL, 0);
      `CHK("coil reset", 32'h0, rd)
      acc(0, ASEP_PAR_ENC_ARM, 0);
      `CHK("arm reset", 32'h0, rd)
      acc(0, 8'hCD, 0);
      `CHK("unknown err", 1'b1, er)
      `CHK("unknown data", 32'h0, rd)
      for (int v = 1; v < 4; v++)
      begin
         acc(1, ASEP_PAR_STANDSTILL, v);
         acc(0, ASEP_PAR_STANDSTILL, 0);
         `CHK("coil read", 32'(v), rd)
         standby_zero <= 1'b1;
         volt_mode <= 1'b0;
         tick(3);
         `CHK("coil no chopper", 2'h0, coil_mode)
         volt_mode <= 1'b1;
         tick(3);
         `CHK("coil applied", 2'(v), coil_mode)
         standby_zero <= 1'b0;
         tick(3);
         `CHK("coil no zero standby", 2'h0, coil_mode)
      end
      load_in <= 10'h3FF;
      tick(5);
      acc(0, ASEP_PAR_LOAD, 0);
      `CHK("load max", 32'h3FF, rd)
      acc(1, ASEP_PAR_LOAD, 0);
      `CHK("load write refused", 1'b1, er)
      for (int s = 1; s < 4; s++)
      begin
         @(posedge mclk);
         stall_event <= s[0];
         dev_event <= s[1];
         @(posedge mclk);
         stall_event <= 1'b0;
         dev_event <= 1'b0;
         acc(0, ASEP_PAR_STICKY, 0);
         `CHK("sticky set", 32'(s), rd)
         acc(0, ASEP_PAR_STICKY, 0);
         `CHK("sticky cleared by read", 32'h0, rd)
      end
      @(posedge mclk);
      stall_event <= 1'b1;
      dev_event <= 1'b1;
      @(posedge mclk);
      stall_event <= 1'b0;
      dev_event <= 1'b0;
      motion_cmd <= 1'b1;
      @(posedge mclk);
      motion_cmd <= 1'b0;
      acc(0, ASEP_PAR_STICKY, 0);
      `CHK("sticky motion clear", 32'h0, rd)
      @(posedge mclk);
      stall_event <= 1'b1;
      @(posedge mclk);
      stall_event <= 1'b0;
      acc(1, ASEP_PAR_STICKY, 32'h0);
      `CHK("sticky write refused", 1'b1, er)
      acc(0, ASEP_PAR_STICKY, 0);
      `CHK("sticky kept by write", 32'h1, rd)
      acc(1, ASEP_PAR_DIAG, 32'h0);
      `CHK("diag write refused", 1'b1, er)
      // One fault line at a time, read twice to show the bits are not cleared
      for (int i = 0; i < 7; i++)
      begin
         drv_in <= asep_drv_t'(7'h40 >> i);
         tick(5);
         acc(0, ASEP_PAR_DIAG, 0);
         `CHK("diag bit", 32'h80 | (32'h1 << i), rd)
         acc(0, ASEP_PAR_DIAG, 0);
         `CHK("diag live", 32'h80 | (32'h1 << i), rd)
      end
      drv_in <= '0;
      @(posedge mclk);
      step_pulse <= 1'b1;
      @(posedge mclk);
      step_pulse <= 1'b0;
      tick(4);
      acc(0, ASEP_PAR_DIAG, 0);
      `CHK("standstill after step", 32'h0, rd)
      tick(20);
      acc(0, ASEP_PAR_DIAG, 0);
      `CHK("standstill again", 32'h80, rd)
      acc(1, ASEP_PAR_ENC_COUNT, 32'h7FFFFFFF);
      `CHK("enc write", 1'b0, er)
      @(posedge mclk);
      enc_inc <= 1'b1;
      @(posedge mclk);
      enc_inc <= 1'b0;
      acc(0, ASEP_PAR_ENC_COUNT, 0);
      `CHK("enc wrap up", 32'h80000000, rd)
      @(posedge mclk);
      enc_dec <= 1'b1;
      @(posedge mclk);
      enc_dec <= 1'b0;
      acc(0, ASEP_PAR_ENC_COUNT, 0);
      `CHK("enc wrap down", 32'h7FFFFFFF, rd)
      @(posedge mclk);
      enc_inc <= 1'b1;
      enc_dec <= 1'b1;
      @(posedge mclk);
      enc_inc <= 1'b0;
      enc_dec <= 1'b0;
      acc(0, ASEP_PAR_ENC_COUNT, 0);
      `CHK("enc both ways", 32'h7FFFFFFF, rd)
      acc(1, ASEP_PAR_ENC_COUNT, 32'h5);
      acc(1, ASEP_PAR_ENC_ARM, 32'h1);
      acc(0, ASEP_PAR_ENC_ARM, 0);
      `CHK("arm set", 32'h1, rd)
      // A second zero pass after the first clear must leave the count alone
      for (int p = 0; p < 2; p++)
      begin
         @(posedge mclk);
         enc_zero <= 1'b1;
         @(posedge mclk);
         enc_zero <= 1'b0;
         acc(0, ASEP_PAR_ENC_COUNT, 0);
         `CHK("enc zero clear", p ? 32'h7 : 32'h0, rd)
         acc(0, ASEP_PAR_ENC_ARM, 0);
         `CHK("arm dropped", 32'h0, rd)
         acc(1, ASEP_PAR_ENC_COUNT, 32'h7);
      end
      tally_and_finish;
   end
endmodule
